// ---- design/pims_pkg.sv ----
// Package for the PHY interrupt mask and link status register slice.
// Assumes a station management front end that presents decoded register
// reads and writes as one-cycle strobes on the system clock.
package pims_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_INTERRUPT_MASK = 5'h16; // Mask register
  localparam logic [4:0] ADDR_LINK_COMM_STATUS = 5'h17; // Status register

  // ----------------------------------------------------------------
  // Mask register layout and reset values
  // ----------------------------------------------------------------
  localparam int POWER_ON_EVENT_MASK_POS = 15; // Power-on enable bit
  localparam int MASK_RESERVED_POS = 4; // Reserved, reads zero
  localparam logic [15:0] MASK_RESET_FIRST = 16'h8000; // First port block
  localparam logic [15:0] MASK_RESET_SECOND = 16'h0000; // Second block
  localparam logic [15:0] MASK_WRITABLE = 16'hffef; // Bit 4 not stored

  // ----------------------------------------------------------------
  // Event source bit positions
  // ----------------------------------------------------------------
  localparam int WAKE_EVENT_POS = 14; // Wake-up event
  localparam int LINK_FAIL_EVENT_POS = 10; // Link OK to fail
  localparam int LINK_UP_EVENT_POS = 9; // Link fail to OK
  localparam int SYMBOL_FAULT_EVENT_POS = 8; // Symbol error
  localparam int QUALITY_LOW_EVENT_POS = 6; // Quality warning
  // Events cleared on sleep request or standby undervoltage
  localparam logic [15:0] LINK_EVENT_GROUP = 16'h0740;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int LINK_UP_POS = 15; // Link OK
  localparam int TX_MODE_LSB = 13; // Transmitter mode field
  localparam int LOCAL_RX_POS = 12; // Local receiver OK, latch low
  localparam int REMOTE_RX_POS = 11; // Remote receiver OK, latch low
  localparam int DESCRAMBLER_POS = 10; // Descrambler lock
  localparam int START_FAULT_POS = 9; // Start delimiter fault
  localparam int END_FAULT_POS = 8; // End delimiter fault
  localparam int QUALITY_LSB = 5; // Signal quality class
  localparam int RX_ERR_POS = 4; // Receive error, latch high
  localparam int TX_ERR_POS = 3; // Transmit error, latch high
  localparam int STATE_LSB = 0; // Operating state field

  // Transmitter mode codes
  typedef enum logic [1:0] {
    TX_OFF_MODE = 2'b00,
    TX_SEND_N = 2'b01,
    TX_SEND_I = 2'b10,
    TX_SEND_Z = 2'b11
  } pims_tx_mode_type;

  // Operating state codes
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INIT = 3'b001,
    ST_CONFIGURED = 3'b010,
    ST_OFFLINE = 3'b011,
    ST_ACTIVE = 3'b100,
    ST_ISOLATE = 3'b101,
    ST_CABLE_TEST = 3'b110,
    ST_TEST_MODE = 3'b111
  } pims_state_type;

  localparam logic [2:0] QUALITY_CLASS_D = 3'b100; // Error rate < 1e-10

endpackage

// ---- design/pims_event_latch.sv ----
// Latch-high event source register with read clear and group clear.
// Assumes events and strobes are already on the system clock.
`timescale 1ns/10ps
module pims_event_latch #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_set, // Event pulses or levels
  input wire logic [WIDTH-1:0] i_group_clr, // Per-bit forced clear
  input wire logic i_read, // Read of the source register
  output logic [WIDTH-1:0] o_latched
);

  // Refuse an empty latch bank when the design is built
  if (WIDTH < 1) begin : g_bad_width
    $error("pims_event_latch: WIDTH must be positive");
  end

  // ----------------------------------------------------------------
  // One latch per bit
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // Set wins over read clear so no event is lost
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          o_latched[g] <= 1'b0;
        end else if (i_set[g]) begin
          o_latched[g] <= 1'b1;
        end else if (i_read || i_group_clr[g]) begin
          o_latched[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ---- design/pims_regs.sv ----
// Interrupt mask register, communication status register and the
// event source latches behind the active-low interrupt output.
// Assumes the management front end decodes address and gives one-cycle
// read and write strobes; all status inputs are synchronous to i_clk_sys.
`timescale 1ns/10ps

// Summary of operation
// - Disabled event never pulls interrupt low
// - Mask leaves event latching untouched
// - Power-on enable resets 1 first, 0 second
// - Sleep or undervoltage clears link event bits
// - Read clears wake; detection off until transition
// - Transmitter mode field codes at 14:13
// - Quality class field codes at 7:5
// - Local receiver OK bit latches low
// - Remote receiver OK bit latches low
// - Start delimiter fault latches high
// - End delimiter fault latches high
// - Receive error latches high until read
// - Transmit error latches high until read
// - Event bits latch high, clear on read
module pims_regs #(
  parameter bit SECOND_PORT = 1'b0 // Selects second port block reset
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Register access from the management front end
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr, // One-cycle write strobe
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_rd, // One-cycle read strobe
  input wire logic i_src_rd, // Read of event source register
  output logic [15:0] o_reg_rdata, // Registered read data
  output logic [15:0] o_event_src, // Latched event sources
  // Event inputs, one bit per source position
  input wire logic [15:0] i_event,
  input wire logic i_wake_detect, // Raw wake detection
  input wire logic i_state_change, // State machine done a transition
  input wire logic i_sleep_req_entry, // Entering sleep request
  input wire logic i_standby_uv_entry, // Standby due to undervoltage
  input wire logic i_standby_uv_detect, // Undervoltage in standby
  // Live status
  input wire logic i_link_up,
  input wire logic [1:0] i_tx_mode,
  input wire logic i_local_receiver_ok,
  input wire logic i_remote_receiver_ok,
  input wire logic i_descrambler_lock_flag,
  input wire logic i_start_delimiter_fault,
  input wire logic i_end_delimiter_fault,
  input wire logic [2:0] i_quality_class,
  input wire logic i_rx_error,
  input wire logic i_tx_error,
  input wire logic [2:0] i_operating_state_field,
  output logic o_int_b // Active-low interrupt
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] mask_reg; // Interrupt enables
  logic wake_armed_reg; // Wake detection enabled
  logic link_up_d_reg; // Previous link status
  logic local_ok_reg; // Latch-low local receiver
  logic remote_ok_reg; // Latch-low remote receiver
  logic start_fault_reg; // Latch-high delimiter faults
  logic end_fault_reg;
  logic rx_err_reg; // Latch-high error bits
  logic tx_err_reg;
  logic [15:0] event_set; // Combined set vector
  logic [15:0] group_clr; // Forced clear vector
  logic [15:0] status_word; // Assembled status view
  logic status_rd; // Read of the status register
  logic sleep_clr; // Any of three clear occasions
  logic int_next;

  assign status_rd = i_reg_rd &&
                     (i_reg_addr == pims_pkg::ADDR_LINK_COMM_STATUS);
  assign sleep_clr = i_sleep_req_entry || i_standby_uv_entry ||
                     i_standby_uv_detect;

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  // Reserved bit is not stored, so it reads zero whatever is written
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      mask_reg <= SECOND_PORT ? pims_pkg::MASK_RESET_SECOND
                              : pims_pkg::MASK_RESET_FIRST;
    end else if (i_reg_wr &&
                 (i_reg_addr == pims_pkg::ADDR_INTERRUPT_MASK)) begin
      mask_reg <= i_reg_wdata & pims_pkg::MASK_WRITABLE;
    end
  end

  // ----------------------------------------------------------------
  // Wake arming and link edge tracking
  // ----------------------------------------------------------------
  // Once read, wake stays off until the state machine moves on
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      wake_armed_reg <= 1'b1;
    end else if (i_state_change) begin
      wake_armed_reg <= 1'b1;
    end else if (i_src_rd && o_event_src[pims_pkg::WAKE_EVENT_POS]) begin
      wake_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      link_up_d_reg <= 1'b0;
    end else begin
      link_up_d_reg <= i_link_up;
    end
  end

  // Set and clear vectors for the source latches
  always_comb begin
    event_set = i_event;
    event_set[pims_pkg::WAKE_EVENT_POS] = i_wake_detect && wake_armed_reg;
    event_set[pims_pkg::LINK_FAIL_EVENT_POS] =
      link_up_d_reg && !i_link_up;
    event_set[pims_pkg::LINK_UP_EVENT_POS] = !link_up_d_reg && i_link_up;
    event_set[pims_pkg::MASK_RESERVED_POS] = 1'b0;
    // Clearing takes priority in the group so the bits restart clean
    group_clr = sleep_clr ? pims_pkg::LINK_EVENT_GROUP : 16'h0000;
    event_set = event_set & ~group_clr;
  end

  // ----------------------------------------------------------------
  // Event source latches, independent of the mask
  // ----------------------------------------------------------------
  pims_event_latch #(
    .WIDTH(16)
  ) u_src (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_set(event_set),
    .i_group_clr(group_clr),
    .i_read(i_src_rd),
    .o_latched(o_event_src)
  );

  // ----------------------------------------------------------------
  // Latched status bits
  // ----------------------------------------------------------------
  // Not-OK beats the read clear so no drop is missed
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      local_ok_reg <= 1'b0;
      remote_ok_reg <= 1'b0;
    end else begin
      if (!i_local_receiver_ok) begin
        local_ok_reg <= 1'b0;
      end else if (status_rd) begin
        local_ok_reg <= 1'b1;
      end
      if (!i_remote_receiver_ok) begin
        remote_ok_reg <= 1'b0;
      end else if (status_rd) begin
        remote_ok_reg <= 1'b1;
      end
    end
  end

  // Errors set over read clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      start_fault_reg <= 1'b0;
      end_fault_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      tx_err_reg <= 1'b0;
    end else begin
      start_fault_reg <= i_start_delimiter_fault ||
                         (start_fault_reg && !status_rd);
      end_fault_reg <= i_end_delimiter_fault ||
                       (end_fault_reg && !status_rd);
      rx_err_reg <= i_rx_error || (rx_err_reg && !status_rd);
      tx_err_reg <= i_tx_error || (tx_err_reg && !status_rd);
    end
  end

  // Status view, fields passed as coded by the transmitter and state logic
  always_comb begin
    status_word = 16'h0000;
    status_word[pims_pkg::LINK_UP_POS] = i_link_up;
    status_word[pims_pkg::TX_MODE_LSB +: 2] = i_tx_mode;
    status_word[pims_pkg::LOCAL_RX_POS] = local_ok_reg;
    status_word[pims_pkg::REMOTE_RX_POS] = remote_ok_reg;
    status_word[pims_pkg::DESCRAMBLER_POS] = i_descrambler_lock_flag;
    status_word[pims_pkg::START_FAULT_POS] = start_fault_reg;
    status_word[pims_pkg::END_FAULT_POS] = end_fault_reg;
    status_word[pims_pkg::QUALITY_LSB +: 3] = i_quality_class;
    status_word[pims_pkg::RX_ERR_POS] = rx_err_reg;
    status_word[pims_pkg::TX_ERR_POS] = tx_err_reg;
    status_word[pims_pkg::STATE_LSB +: 3] =
      i_operating_state_field;
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        pims_pkg::ADDR_INTERRUPT_MASK: begin
          o_reg_rdata <= mask_reg;
        end
        pims_pkg::ADDR_LINK_COMM_STATUS: begin
          o_reg_rdata <= status_word;
        end
        default: begin
          o_reg_rdata <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Same-position AND of sources and enables; one cycle behind latches
  assign int_next = |(o_event_src & mask_reg);
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_int_b <= 1'b1;
    end else begin
      o_int_b <= !int_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Wake read with no new detection racing it (set would win there)
  sequence s_wake_cleared;
    i_src_rd && o_event_src[pims_pkg::WAKE_EVENT_POS] && !i_wake_detect &&
      !i_state_change;
  endsequence
  // Receiver drop that recovers before any status read
  sequence s_local_dropout;
    !i_local_receiver_ok ##1 (i_local_receiver_ok && !status_rd);
  endsequence

  chk_int_masked: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    ((o_event_src & mask_reg) == 16'h0000) |=> o_int_b)
    else $error("interrupt asserted with no enabled source");
  chk_int_active: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    ((o_event_src & mask_reg) != 16'h0000) |=> !o_int_b)
    else $error("interrupt not asserted for enabled source");
  chk_src_latch: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (event_set != 16'h0000) |=>
      ((o_event_src & $past(event_set)) == $past(event_set)))
    else $error("event source did not latch");
  chk_group_clear: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    sleep_clr |=> ((o_event_src & pims_pkg::LINK_EVENT_GROUP) == 16'h0000))
    else $error("link event group not cleared");
  chk_mask_rsvd: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !mask_reg[pims_pkg::MASK_RESERVED_POS])
    else $error("reserved mask bit stored");
  chk_wake_block: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_wake_cleared ##1 (!i_state_change)[*2] |->
      !o_event_src[pims_pkg::WAKE_EVENT_POS])
    else $error("wake event set while disarmed");
  chk_local_low: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_local_dropout |=> !local_ok_reg)
    else $error("local receiver bit did not hold low");
  chk_remote_low: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_remote_receiver_ok |=> !remote_ok_reg)
    else $error("remote receiver bit not low");
  chk_err_hold: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (rx_err_reg && !status_rd) |=> rx_err_reg)
    else $error("receive error lost before read");
  chk_txerr_set: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_tx_error |=> tx_err_reg)
    else $error("transmit error not latched");

endmodule

// ---- test/pims_host_model.sv ----
// Station management host model driving decoded register strobes.
// Assumes the bench calls its tasks; strobes move on the falling edge.
`timescale 1ns/10ps
module pims_host_model (
  input wire logic i_clk_sys,
  output logic [4:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [15:0] o_reg_wdata,
  output logic o_reg_rd,
  output logic o_src_rd,
  input wire logic [15:0] i_reg_rdata,
  input wire logic [15:0] i_event_src,
  input wire logic i_io_supply_low_flag
);
  // --------------------------------------------------------------
  // Idle bus
  // --------------------------------------------------------------
  initial begin
    o_reg_addr = 5'h00;
    o_reg_wr = 1'b0;
    o_reg_wdata = 16'h0000;
    o_reg_rd = 1'b0;
    o_src_rd = 1'b0;
  end

  // --------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------
  // One-cycle write; reserved mask bit always sent as zero
  task automatic wr(input logic [4:0] addr, input logic [15:0] data);
    @(negedge i_clk_sys);
    o_reg_addr = addr;
    o_reg_wdata = data & 16'hffef;
    o_reg_wr = 1'b1;
    @(negedge i_clk_sys);
    o_reg_wr = 1'b0;
    // Released data is scrambled so a stale value is never reused
    o_reg_wdata = ~o_reg_wdata;
  endtask

  // One-cycle read; data taken a full cycle after the strobe edge
  task automatic rd(input logic [4:0] addr, output logic [15:0] data);
    @(negedge i_clk_sys);
    o_reg_addr = addr;
    o_reg_rd = 1'b1;
    @(negedge i_clk_sys);
    o_reg_rd = 1'b0;
    @(negedge i_clk_sys);
    data = i_reg_rdata;
  endtask

  // Source read: value taken before the clearing strobe
  task automatic src_rd(output logic [15:0] data);
    @(negedge i_clk_sys);
    data = i_event_src;
    // Wake bit is untrustworthy while the IO supply is low
    if (i_io_supply_low_flag) begin
      data[14] = 1'b0;
    end
    o_src_rd = 1'b1;
    @(negedge i_clk_sys);
    o_src_rd = 1'b0;
  endtask
endmodule

// ---- test/phy_irq_mask_and_link_status_test.sv ----
// Bench for the mask and status slice: host model issues register
// strobes, the bench drives event and status inputs on the falling edge.
// Assumes pims_pkg, pims_regs and pims_host_model compile first.
`timescale 1ns/10ps
module phy_irq_mask_and_link_status_test;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk_sys = 1'b0; // 20 MHz system clock
  logic rst_b = 1'b0; // Reset, active low
  logic [4:0] reg_addr; // Host driven
  logic reg_wr, reg_rd, src_rd; // Host strobes
  logic [15:0] reg_wdata, reg_rdata, event_src;
  logic [15:0] event_in = 16'h0000; // Event pulses
  logic wake = 1'b0, state_chg = 1'b0, link_up = 1'b0;
  logic [2:0] grp_clr = 3'b000; // Sleep, standby uv, uv in standby
  logic [1:0] tx_mode = 2'b00;
  logic loc_ok = 1'b1, rem_ok = 1'b1, desc_lock = 1'b0;
  logic [3:0] faults = 4'h0; // Start, end, rx, tx faults
  logic [2:0] quality = 3'b000, op_state = 3'b000;
  logic int_b; // Interrupt, active low
  logic [15:0] reg_rdata2; // Second port block read data
  logic int_b2; // Second port block interrupt, active low
  logic [15:0] d; // Last word read
  int mismatches = 0;
  int comparisons = 0;

  // --------------------------------------------------------------
  // Clock and instances
  // --------------------------------------------------------------
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  pims_host_model host_u (.i_clk_sys(clk_sys), .o_reg_addr(reg_addr),
    .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd),
    .o_src_rd(src_rd), .i_reg_rdata(reg_rdata), .i_event_src(event_src),
    .i_io_supply_low_flag(1'b0));

  pims_regs #(.SECOND_PORT(1'b0)) dut_u (.i_clk_sys(clk_sys),
    .i_rst_b(rst_b), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .i_src_rd(src_rd),
    .o_reg_rdata(reg_rdata), .o_event_src(event_src), .i_event(event_in),
    .i_wake_detect(wake), .i_state_change(state_chg),
    .i_sleep_req_entry(grp_clr[0]), .i_standby_uv_entry(grp_clr[1]),
    .i_standby_uv_detect(grp_clr[2]), .i_link_up(link_up),
    .i_tx_mode(tx_mode), .i_local_receiver_ok(loc_ok),
    .i_remote_receiver_ok(rem_ok), .i_descrambler_lock_flag(desc_lock),
    .i_start_delimiter_fault(faults[3]), .i_end_delimiter_fault(faults[2]),
    .i_quality_class(quality), .i_rx_error(faults[1]),
    .i_tx_error(faults[0]), .i_operating_state_field(op_state),
    .o_int_b(int_b));

  // Second port block on the same bus; only its reset values differ
  pims_regs #(.SECOND_PORT(1'b1)) dut2_u (.i_clk_sys(clk_sys),
    .i_rst_b(rst_b), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .i_src_rd(src_rd),
    .o_reg_rdata(reg_rdata2), .o_event_src(), .i_event(event_in),
    .i_wake_detect(wake), .i_state_change(state_chg),
    .i_sleep_req_entry(grp_clr[0]), .i_standby_uv_entry(grp_clr[1]),
    .i_standby_uv_detect(grp_clr[2]), .i_link_up(link_up),
    .i_tx_mode(tx_mode), .i_local_receiver_ok(loc_ok),
    .i_remote_receiver_ok(rem_ok), .i_descrambler_lock_flag(desc_lock),
    .i_start_delimiter_fault(faults[3]), .i_end_delimiter_fault(faults[2]),
    .i_quality_class(quality), .i_rx_error(faults[1]),
    .i_tx_error(faults[0]), .i_operating_state_field(op_state),
    .o_int_b(int_b2));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle event pulse, then one cycle for the interrupt to follow
  task automatic pulse_ev(input logic [15:0] v);
    @(negedge clk_sys);
    event_in = v;
    @(negedge clk_sys);
    event_in = 16'h0000;
    @(negedge clk_sys);
  endtask

  // Link events: rise then fall, plus symbol and quality events
  task automatic set_group();
    pulse_ev(16'h0140);
    @(negedge clk_sys) link_up = 1'b1;
    @(negedge clk_sys) link_up = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // Wake detection pulse
  task automatic pulse_wake();
    @(negedge clk_sys) wake = 1'b1;
    @(negedge clk_sys) wake = 1'b0;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    host_u.rd(pims_pkg::ADDR_INTERRUPT_MASK, d);
    check("mask reset", d & 16'hffef, pims_pkg::MASK_RESET_FIRST);
    check("mask reset 2", reg_rdata2, pims_pkg::MASK_RESET_SECOND);
    check("int idle", {15'h0, int_b}, 16'h0001);
    $display("test reset done");
  endtask

  task automatic t_mask();
    host_u.wr(pims_pkg::ADDR_INTERRUPT_MASK, 16'hffff);
    host_u.rd(pims_pkg::ADDR_INTERRUPT_MASK, d);
    check("mask all", d & 16'hffef, 16'hffef);
    host_u.rd(5'h03, d);
    check("unmapped", d, 16'h0000);
    $display("test mask done");
  endtask

  task automatic t_irq();
    host_u.wr(pims_pkg::ADDR_INTERRUPT_MASK, 16'h0100);
    pulse_ev(16'h0040);
    check("masked int", {15'h0, int_b}, 16'h0001);
    pulse_ev(16'h0100);
    check("enabled int", {15'h0, int_b}, 16'h0000);
    check("enabled int 2", {15'h0, int_b2}, 16'h0000);
    host_u.src_rd(d);
    check("sources", d, 16'h0140);
    repeat (2) @(negedge clk_sys);
    check("int cleared", {15'h0, int_b}, 16'h0001);
    host_u.src_rd(d);
    check("sources clear", d, 16'h0000);
    $display("test interrupt done");
  endtask

  task automatic t_group();
    host_u.wr(pims_pkg::ADDR_INTERRUPT_MASK, 16'h0740);
    set_group();
    host_u.src_rd(d);
    check("link group", d, 16'h0740);
    // Each of the three clearing occasions in turn
    for (int k = 0; k < 3; k++) begin
      set_group();
      check("group int", {15'h0, int_b}, 16'h0000);
      @(negedge clk_sys) grp_clr[k] = 1'b1;
      @(negedge clk_sys) grp_clr[k] = 1'b0;
      @(negedge clk_sys);
      check("group int off", {15'h0, int_b}, 16'h0001);
      host_u.src_rd(d);
      check("group clear", d, 16'h0000);
    end
    $display("test group clear done");
  endtask

  task automatic t_wake();
    pulse_wake();
    host_u.src_rd(d);
    check("wake set", d, 16'h4000);
    pulse_wake();
    host_u.src_rd(d);
    check("wake disarmed", d, 16'h0000);
    @(negedge clk_sys) state_chg = 1'b1;
    @(negedge clk_sys) state_chg = 1'b0;
    pulse_wake();
    host_u.src_rd(d);
    check("wake rearmed", d, 16'h4000);
    $display("test wake done");
  endtask

  task automatic t_fields();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      tx_mode = 2'(i);
      quality = 3'(i);
      op_state = 3'(i);
      desc_lock = i[0];
      host_u.rd(pims_pkg::ADDR_LINK_COMM_STATUS, d);
      check("tx mode", 16'(d[14:13]), 16'(i[1:0]));
      check("quality", 16'(d[7:5]), 16'(i[2:0]));
      check("state", 16'(d[2:0]), 16'(i[2:0]));
      check("lock", 16'(d[10]), 16'(i[0]));
    end
    $display("test fields done");
  endtask

  task automatic t_latch();
    host_u.rd(pims_pkg::ADDR_LINK_COMM_STATUS, d);
    host_u.rd(pims_pkg::ADDR_LINK_COMM_STATUS, d);
    check("rx ok", d & 16'h1818, 16'h1800);
    // Brief dropout that recovers before the read
    @(negedge clk_sys) {loc_ok, rem_ok, faults} = 6'h0f;
    @(negedge clk_sys) {loc_ok, rem_ok, faults} = 6'h30;
    host_u.rd(pims_pkg::ADDR_LINK_COMM_STATUS, d);
    check("latched", d & 16'h1b18, 16'h0318);
    host_u.rd(pims_pkg::ADDR_LINK_COMM_STATUS, d);
    check("after read", d & 16'h1b18, 16'h1800);
    $display("test latch done");
  endtask

  // --------------------------------------------------------------
  // Verdict and sequence
  // --------------------------------------------------------------
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d failed", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset();
    t_mask();
    t_irq();
    t_group();
    t_wake();
    t_fields();
    t_latch();
    give_verdict();
  end

  // Hang guard: 20000 cycles
  initial begin
    #1000000;
    mismatches++;
    give_verdict();
  end
endmodule
